// >>> include/psc_cfg.svh
// register offsets, field positions and reset values of the power supply control bank
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

`define PSC_ADDR_W           8
`define PSC_OFF_CONV_CTL     8'h2c
`define PSC_OFF_SUP_STAT     8'h30
`define PSC_OFF_CORE_LVL     8'h34
`define PSC_OFF_PLL_LVL      8'h40
`define PSC_OFF_IRQ_STAT     8'h44
`define PSC_OFF_IRQ_MASK     8'h48

`define PSC_CTL_PG_LSB       24
`define PSC_CTL_ERRCLR_BIT   16
`define PSC_CTL_AUX_ILIM_LSB 13
`define PSC_CTL_AUX_CLK_LSB  8
`define PSC_CTL_CORE_ILIM_LSB 5
`define PSC_CTL_CORE_CLK_LSB 0
`define PSC_CTL_WR_MASK      32'h0301_6363
`define PSC_CTL_RESET        32'h0200_0101

`define PSC_ST_OSC_BIT       24
`define PSC_ST_PLL_GOOD_BIT  19
`define PSC_ST_CORE_GOOD_BIT 16
`define PSC_ST_AUX_ILIM_BIT  9
`define PSC_ST_CORE_ILIM_BIT 8
`define PSC_ST_AUX_SS_BIT    1
`define PSC_ST_CORE_SS_BIT   0
`define PSC_ST_MASK          32'h0109_0303

`define PSC_CORE_LVL_W       7
`define PSC_PLL_LVL_MAX_W    8
`define PSC_PLL_LVL_DEF_W    4

`endif

// >>> include/psc_pkg.sv
// types shared by the power supply control register bank
package psc_pkg;

  typedef struct packed {
    logic       osc_stable;
    logic       pll_rail_good;
    logic       core_rail_good;
    logic       aux_buck_ilim;
    logic       core_buck_ilim;
    logic       aux_buck_softstart;
    logic       core_buck_softstart;
  } psc_status_t;

  typedef struct packed {
    logic [1:0] power_good_thr;
    logic       err_clear;
    logic [1:0] aux_buck_ilim;
    logic [1:0] aux_buck_clk;
    logic [1:0] core_buck_ilim;
    logic [1:0] core_buck_clk;
  } psc_ctl_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } psc_avl_req_t;

  typedef struct packed {
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic        strap_done_q;
    logic [31:0] conv_ctl_q;
    logic [6:0]  core_lvl_q;
    logic [7:0]  pll_lvl_q;
    logic [31:0] irq_stat_q;
    logic [31:0] irq_mask_q;
    logic [31:0] stat_prev_q;
  } psc_state_t;

endpackage

// >>> hw/psc_regs.sv
// avalon-mm register bank controlling and monitoring the on-chip converters and regulator
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "psc_cfg.svh"

module psc_regs
  import psc_pkg::*;
#(
  parameter int PLL_LVL_W = `PSC_PLL_LVL_DEF_W
)(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic [`PSC_ADDR_W-1:0]     avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire psc_status_t                status_i,
  input  wire logic [`PSC_CORE_LVL_W-1:0] core_rail_strap_i,
  input  wire logic [PLL_LVL_W-1:0]       pll_reg_strap_i,
  output psc_ctl_t                        ctl_o,
  output logic      [`PSC_CORE_LVL_W-1:0] core_rail_level_o,
  output logic      [PLL_LVL_W-1:0]       pll_reg_level_o,
  output logic                            irq_o
);

  // code 6 of the regulator level needs three bits; the field cannot pass the byte it sits in
  if (PLL_LVL_W < 3 || PLL_LVL_W > `PSC_PLL_LVL_MAX_W)
  begin : g_bad_width
    $error("psc_regs: PLL_LVL_W must lie between 3 and 8");
  end

  localparam logic [31:0] PLL_WR_MASK = 32'((1 << PLL_LVL_W) - 1);
  localparam logic [31:0] CORE_WR_MASK = 32'h0000_007f;

  psc_state_t   s_q;
  psc_state_t   s_d;
  psc_avl_req_t req;
  logic [31:0]  be_mask;
  logic [31:0]  stat_word;
  logic [31:0]  stat_rise;
  logic         acc;
  logic         commit;

  assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                 writedata: avs_writedata_i, byteenable: avs_byteenable_i};

  for (genvar i = 0; i < 4; i++)
  begin : g_be
    assign be_mask[8*i +: 8] = {8{req.byteenable[i]}};
  end

  always_comb
  begin
    stat_word = '0;
    stat_word[`PSC_ST_OSC_BIT]       = status_i.osc_stable;
    stat_word[`PSC_ST_PLL_GOOD_BIT]  = status_i.pll_rail_good;
    stat_word[`PSC_ST_CORE_GOOD_BIT] = status_i.core_rail_good;
    stat_word[`PSC_ST_AUX_ILIM_BIT]  = status_i.aux_buck_ilim;
    stat_word[`PSC_ST_CORE_ILIM_BIT] = status_i.core_buck_ilim;
    stat_word[`PSC_ST_AUX_SS_BIT]    = status_i.aux_buck_softstart;
    stat_word[`PSC_ST_CORE_SS_BIT]   = status_i.core_buck_softstart;
  end

  // an event is any status bit going from zero to one
  assign stat_rise = stat_word & ~s_q.stat_prev_q & `PSC_ST_MASK;

  assign acc = req.read | req.write;
  // one wait cycle: the request is answered on the edge after it is first seen
  assign commit = acc & ~s_q.wait_q;

  always_comb
  begin
    s_d = s_q;
    s_d.stat_prev_q = stat_word;
    s_d.wait_q = ~(acc & s_q.wait_q);
    s_d.irq_stat_q = s_q.irq_stat_q | stat_rise;

    // straps are caught on the first edge after reset release, never under the reset
    if (!s_q.strap_done_q)
    begin
      s_d.strap_done_q = 1'b1;
      s_d.core_lvl_q = core_rail_strap_i;
      s_d.pll_lvl_q = 8'(pll_reg_strap_i);
    end

    if (acc & s_q.wait_q & req.read)
    begin
      unique case (req.address)
        `PSC_OFF_CONV_CTL: s_d.rdata_q = s_q.conv_ctl_q;
        `PSC_OFF_SUP_STAT: s_d.rdata_q = stat_word;
        `PSC_OFF_CORE_LVL: s_d.rdata_q = 32'(s_q.core_lvl_q);
        `PSC_OFF_PLL_LVL:  s_d.rdata_q = 32'(s_q.pll_lvl_q);
        `PSC_OFF_IRQ_STAT: s_d.rdata_q = s_q.irq_stat_q;
        `PSC_OFF_IRQ_MASK: s_d.rdata_q = s_q.irq_mask_q;
        default:           s_d.rdata_q = '0;
      endcase
    end

    if (commit & req.read & (req.address == `PSC_OFF_IRQ_STAT))
    begin
      // clear on read, but an event landing in the same cycle stays set
      s_d.irq_stat_q = stat_rise;
    end

    if (commit & req.write)
    begin
      unique case (req.address)
        `PSC_OFF_CONV_CTL:
        begin
          s_d.conv_ctl_q = (s_q.conv_ctl_q & ~(be_mask & `PSC_CTL_WR_MASK)) |
                           (req.writedata & be_mask & `PSC_CTL_WR_MASK);
        end
        `PSC_OFF_CORE_LVL:
        begin
          s_d.core_lvl_q = 7'((32'(s_q.core_lvl_q) & ~(be_mask & CORE_WR_MASK)) |
                              (req.writedata & be_mask & CORE_WR_MASK));
        end
        `PSC_OFF_PLL_LVL:
        begin
          s_d.pll_lvl_q = 8'((32'(s_q.pll_lvl_q) & ~(be_mask & PLL_WR_MASK)) |
                             (req.writedata & be_mask & PLL_WR_MASK));
        end
        `PSC_OFF_IRQ_MASK:
        begin
          s_d.irq_mask_q = (s_q.irq_mask_q & ~(be_mask & `PSC_ST_MASK)) |
                           (req.writedata & be_mask & `PSC_ST_MASK);
        end
        default:
        begin
          s_d.irq_mask_q = s_q.irq_mask_q;
        end
      endcase
    end

    s_d.irq_q = |(s_d.irq_stat_q & s_d.irq_mask_q);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
      s_q.conv_ctl_q <= `PSC_CTL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata_q;
  assign avs_waitrequest_o = s_q.wait_q;
  assign irq_o = s_q.irq_q;
  assign core_rail_level_o = s_q.core_lvl_q;
  assign pll_reg_level_o = s_q.pll_lvl_q[PLL_LVL_W-1:0];

  // fields go straight from the register to the converters
  assign ctl_o.power_good_thr = s_q.conv_ctl_q[`PSC_CTL_PG_LSB +: 2];
  assign ctl_o.err_clear = s_q.conv_ctl_q[`PSC_CTL_ERRCLR_BIT];
  assign ctl_o.aux_buck_ilim = s_q.conv_ctl_q[`PSC_CTL_AUX_ILIM_LSB +: 2];
  assign ctl_o.aux_buck_clk = s_q.conv_ctl_q[`PSC_CTL_AUX_CLK_LSB +: 2];
  assign ctl_o.core_buck_ilim = s_q.conv_ctl_q[`PSC_CTL_CORE_ILIM_LSB +: 2];
  assign ctl_o.core_buck_clk = s_q.conv_ctl_q[`PSC_CTL_CORE_CLK_LSB +: 2];

endmodule

// >>> tb/psc_regs_asserts.sv
// assertion checker for the power supply control register bank
`timescale 1ns/1ps
module psc_regs_asserts
  import psc_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire psc_status_t status_i,
  input wire psc_ctl_t    ctl_o,
  input wire logic        irq_o
);
  logic [6:0]  st_q;
  logic [31:0] wd_q;
  logic        wack_q;
  always_ff @(posedge clk_sys_i)
  begin
    st_q <= status_i;
    wd_q <= avs_writedata_i;
    wack_q <= !avs_waitrequest_o && avs_write_i && avs_address_i == 8'h2c;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rack; !avs_waitrequest_o && avs_read_i; endsequence
  sequence s_wack; !avs_waitrequest_o && avs_write_i; endsequence
  sequence s_clr; s_rack ##0 avs_address_i == 8'h44 && status_i == 7'h0 ##1 status_i == 7'h0;
  endsequence
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_rsv; s_rack ##0 avs_address_i == 8'h2c |-> (avs_readdata_o & ~32'h0301_6363) == 32'h0;
  endproperty
  property p_stat; s_rack ##0 avs_address_i == 8'h30 |-> avs_readdata_o ==
    {7'h0, st_q[6], 4'h0, st_q[5], 2'h0, st_q[4], 6'h0, st_q[3:2], 6'h0, st_q[1:0]};
  endproperty
  property p_unm; s_rack ##0 !(avs_address_i inside {8'h2c, 8'h30, 8'h34, 8'h40, 8'h44, 8'h48})
    |-> avs_readdata_o == 32'h0;
  endproperty
  property p_thr; s_wack ##0 avs_address_i == 8'h2c && avs_byteenable_i[3]
    |=> ctl_o.power_good_thr == wd_q[25:24];
  endproperty
  property p_hold; $changed(ctl_o) |-> wack_q; endproperty
  property p_irq; s_clr |=> !irq_o; endproperty
  a_wait: assert property (p_wait) else $error("request not answered after one wait state");
  a_one: assert property (p_one) else $error("answer held longer than one cycle");
  a_rsv: assert property (p_rsv) else $error("reserved control bits read nonzero");
  a_stat: assert property (p_stat) else $error("status read wrong");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_thr: assert property (p_thr) else $error("threshold not written");
  a_hold: assert property (p_hold) else $error("control changed without write");
  a_irq: assert property (p_irq) else $error("interrupt not cleared by status read");
endmodule
bind psc_regs psc_regs_asserts i_chk (.*);

// >>> tb/psc_regs_tb.sv
// self-checking bench for the power supply control register bank
`timescale 1ns/1ps
module psc_regs_tb;
  import psc_pkg::*;
  logic        clk_sys_i = 1'h0, rst_n_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [7:0]  avs_address_i = 8'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, d;
  logic [3:0]  avs_byteenable_i = 4'h0, pll_reg_strap_i = 4'h6, pll_reg_level_o, be;
  logic        avs_waitrequest_o, irq_o;
  psc_status_t status_i = 7'h0;
  psc_ctl_t    ctl_o;
  logic [6:0]  core_rail_strap_i = 7'h46, core_rail_level_o;
  int          mismatches, n_tests, i, k, seed = 56171;
  logic [7:0]  ad [6] = '{8'h2c, 8'h34, 8'h40, 8'h48, 8'h30, 8'h50};
  logic [31:0] wm [6] = '{32'h0301_6363, 32'h7f, 32'hf, 32'h0109_0303, 32'h0, 32'h0};
  logic [31:0] m [6] = '{32'h0200_0101, 32'h46, 32'h6, 32'h0, 32'h0, 32'h0};
  psc_regs i_dut (.*);
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one access; waitrequest and read data are taken at the rising edge that acks
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_byteenable_i <= b;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0)
    begin
      n++;
      mismatches += (n > 20);
      if (n > 20)
        results;
      @(posedge clk_sys_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  function automatic logic [31:0] smap(input logic [6:0] s);
    return {7'h0, s[6], 4'h0, s[5], 2'h0, s[4], 6'h0, s[3:2], 6'h0, s[1:0]};
  endfunction
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    for (i = 0; i < 6; i++)
    begin
      acc(1'b0, ad[i], $random(seed), 4'hf);
      chk(q, m[i]);
    end
    chk(ctl_o, 11'h411);
    chk({core_rail_level_o, pll_reg_level_o}, 11'h466);
    $display("reset values done");
    acc(1'b1, 8'h48, 32'h0, 4'hf);
    for (k = 0; k < 40; k++)
    begin
      i = {$random(seed)} % 6;
      d = $random(seed);
      be = (k == 0) ? 4'hf : 4'($random(seed));
      status_i <= 7'($random(seed));
      if (i == 1 || i == 2)
      begin
        d = m[i] + 32'h1;
        repeat (100) @(posedge clk_sys_i);
      end
      acc(1'b1, ad[i], d, be);
      m[i] = (m[i] & ~(wm[i] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}))
             | (d & wm[i] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
      m[4] = smap(status_i);
      acc(1'b0, ad[i], $random(seed), 4'($random(seed)));
      chk(q, m[i]);
      chk(ctl_o, {m[0][25:24], m[0][16], m[0][14:13], m[0][9:8], m[0][6:5], m[0][1:0]});
      chk({core_rail_level_o, pll_reg_level_o}, {m[1][6:0], m[2][3:0]});
    end
    $display("random access done");
    status_i <= 7'h0;
    repeat (3) @(posedge clk_sys_i);
    acc(1'b0, 8'h44, 32'h0, 4'hf);
    acc(1'b0, 8'h44, 32'h0, 4'hf);
    chk(q, 32'h0);
    // the random phase leaves an arbitrary mask behind
    acc(1'b1, 8'h48, 32'h0, 4'hf);
    status_i <= 7'h01;
    repeat (3) @(negedge clk_sys_i);
    chk(irq_o, 1'b0);
    acc(1'b1, 8'h48, 32'h1, 4'hf);
    status_i <= 7'h0;
    repeat (2) @(negedge clk_sys_i);
    chk(irq_o, 1'b1);
    acc(1'b0, 8'h44, 32'h0, 4'hf);
    chk(q, 32'h1);
    repeat (2) @(negedge clk_sys_i);
    chk(irq_o, 1'b0);
    $display("interrupt done");
    results;
  end
endmodule
